// file: hw/ssx_datapath.sv
// apb-controlled execution datapath: subtract with borrow, swap, xor, direction load
//
// Decided for this implementation: the register addresses and the APB slave port.
module ssx_datapath
  import ssx_pkg::*;
(
  input  wire logic        clk_i,                // core clock, 10 MHz
  input  wire logic        reset_i,              // async reset, active high
  input  wire logic        psel_i,               // apb select
  input  wire logic        penable_i,            // apb access phase
  input  wire logic        pwrite_i,             // apb direction, 1 = write
  input  wire logic [11:0] paddr_i,              // apb byte address
  input  wire logic [31:0] pwdata_i,             // apb write data
  output logic      [31:0] prdata_o,             // apb read data
  output logic             pready_o,             // apb ready
  output logic             pslverr_o,            // apb error, unmapped address
  output logic      [7:0]  port_a_direction_o,   // port a direction register
  output logic      [7:0]  port_b_direction_o,   // port b direction register
  output logic      [7:0]  port_c_direction_o    // port c direction register
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] accum;
  logic [2:0] status;
  logic [11:0] exec_cmd;
  logic [7:0] file_mem [FILE_DEPTH];
  logic [7:0] next_accum;
  logic [2:0] next_status;
  logic [11:0] next_exec_cmd;
  logic [7:0] next_file_mem [FILE_DEPTH];
  logic [7:0] next_dir_a;
  logic [7:0] next_dir_b;
  logic [7:0] next_dir_c;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic access;
  logic in_file;
  logic mapped;
  logic exec_go;
  logic [6:0] bus_idx;
  assign access = psel_i & penable_i & pready_o;
  assign in_file = (paddr_i[11:9] == FILE_REGION);
  assign bus_idx = paddr_i[8:2];
  assign mapped = (paddr_i[1:0] == 2'b00) &&
                  (in_file || paddr_i == ADDR_ACCUM || paddr_i == ADDR_STATUS ||
                   paddr_i == ADDR_EXEC || paddr_i == ADDR_DIR_A ||
                   paddr_i == ADDR_DIR_B || paddr_i == ADDR_DIR_C);
  // a write to the exec register runs the instruction at the write edge
  assign exec_go = access & pwrite_i & (paddr_i == ADDR_EXEC);

  // instruction fields taken straight from the write data
  ssx_op_t op;
  logic dest_file;
  logic [6:0] f_addr;
  logic [7:0] lit;
  logic [7:0] file_sel;
  assign op = ssx_op_t'(pwdata_i[2:0]);
  assign dest_file = pwdata_i[EXEC_DEST_BIT];
  assign f_addr = pwdata_i[EXEC_OPND_LSB +: 7];
  assign lit = pwdata_i[EXEC_OPND_LSB +: 8];
  assign file_sel = file_mem[f_addr];

  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic alu_upd_cdc;
  logic alu_upd_z;
  logic alu_has_res;

  ssx_alu u_alu (
    .op_i(op),
    .accum_i(accum),
    .file_i(file_sel),
    .lit_i(lit),
    .carry_i(status[STAT_C]),
    .result_o(alu_res),
    .carry_o(alu_c),
    .dcarry_o(alu_dc),
    .zero_o(alu_z),
    .upd_cdc_o(alu_upd_cdc),
    .upd_z_o(alu_upd_z),
    .has_res_o(alu_has_res)
  );

  // ----------------------------------------------------------------
  // next-state: software writes, then instruction execution
  // ----------------------------------------------------------------
  always_comb begin
    next_accum = accum;
    next_status = status;
    next_exec_cmd = exec_cmd;
    next_file_mem = file_mem;
    next_dir_a = port_a_direction_o;
    next_dir_b = port_b_direction_o;
    next_dir_c = port_c_direction_o;
    // plain register writes; direction registers only change by instruction
    if (access && pwrite_i && mapped) begin
      if (in_file) begin
        next_file_mem[bus_idx] = pwdata_i[7:0];
      end else if (paddr_i == ADDR_ACCUM) begin
        next_accum = pwdata_i[7:0];
      end else if (paddr_i == ADDR_STATUS) begin
        next_status = pwdata_i[2:0];
      end else if (paddr_i == ADDR_EXEC) begin
        next_exec_cmd = pwdata_i[11:0];
      end
    end
    if (exec_go) begin
      // literal xor always lands in the accumulator
      if (alu_has_res) begin
        if (dest_file && op != OP_XOR_LIT) begin
          next_file_mem[f_addr] = alu_res;
        end else begin
          next_accum = alu_res;
        end
      end
      if (alu_upd_cdc) begin
        next_status[STAT_C] = alu_c;
        next_status[STAT_DC] = alu_dc;
      end
      if (alu_upd_z) begin
        next_status[STAT_Z] = alu_z;
      end
      // operands outside 5..7 load nothing
      if (op == OP_LOAD_DIR) begin
        if (lit == DIR_SEL_A) begin
          next_dir_a = accum;
        end else if (lit == DIR_SEL_B) begin
          next_dir_b = accum;
        end else if (lit == DIR_SEL_C) begin
          next_dir_c = accum;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // apb answer: zero wait states, data latched during setup
  // ----------------------------------------------------------------
  always_comb begin
    next_pready = psel_i & ~penable_i & ~pready_o;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (psel_i && !penable_i) begin
      next_pslverr = ~mapped;
      if (mapped && in_file) begin
        next_prdata = {24'h00_0000, file_mem[bus_idx]};
      end else if (mapped) begin
        case (paddr_i)
          ADDR_ACCUM: next_prdata = {24'h00_0000, accum};
          ADDR_STATUS: next_prdata = {29'h0000_0000, status};
          ADDR_EXEC: next_prdata = {20'h0_0000, exec_cmd};
          ADDR_DIR_A: next_prdata = {24'h00_0000, port_a_direction_o};
          ADDR_DIR_B: next_prdata = {24'h00_0000, port_b_direction_o};
          ADDR_DIR_C: next_prdata = {24'h00_0000, port_c_direction_o};
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // register everything; file array resets to a constant
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      accum <= ACCUM_RST;
      status <= STATUS_RST;
      exec_cmd <= EXEC_RST;
      port_a_direction_o <= DIR_RST;
      port_b_direction_o <= DIR_RST;
      port_c_direction_o <= DIR_RST;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_mem[i] <= FILE_RST;
      end
    end else begin
      accum <= next_accum;
      status <= next_status;
      exec_cmd <= next_exec_cmd;
      port_a_direction_o <= next_dir_a;
      port_b_direction_o <= next_dir_b;
      port_c_direction_o <= next_dir_c;
      prdata_o <= next_prdata;
      pready_o <= next_pready;
      pslverr_o <= next_pslverr;
      file_mem <= next_file_mem;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // reference values computed independently of the alu
  logic [7:0] chk_sub;
  logic chk_c;
  logic chk_dc;
  assign chk_sub = file_sel - accum - {7'h00, ~status[STAT_C]};
  assign chk_c = ({1'b0, file_sel} >= ({1'b0, accum} + {8'h00, ~status[STAT_C]}));
  assign chk_dc = ({1'b0, file_sel[3:0]} >= ({1'b0, accum[3:0]} + {4'h0, ~status[STAT_C]}));

  AST_SUB_RESULT: assert property (
    exec_go && op == OP_SUB_BORROW && !dest_file |=> accum == $past(chk_sub))
    else $error("subtract with borrow gave a wrong accumulator");
  AST_SUB_FLAGS: assert property (
    exec_go && op == OP_SUB_BORROW |=> status[STAT_Z] == (($past(chk_sub)) == 8'h00))
    else $error("subtract with borrow zero flag wrong");
  AST_SUB_CARRY: assert property (
    exec_go && op == OP_SUB_BORROW |=>
      status[STAT_C] == $past(chk_c) && status[STAT_DC] == $past(chk_dc))
    else $error("subtract carry or digit carry wrong");
  AST_DEST_FILE: assert property (
    exec_go && op == OP_XOR_FILE && dest_file |=>
      file_mem[$past(f_addr)] == $past(accum ^ file_sel) && $stable(accum))
    else $error("file destination not honoured");
  AST_SWAP: assert property (
    exec_go && op == OP_NIBBLE_SWAP && !dest_file |=>
      accum == {$past(file_sel[3:0]), $past(file_sel[7:4])} && $stable(status))
    else $error("nibble exchange wrong or flags touched");
  AST_XOR_LIT: assert property (
    exec_go && op == OP_XOR_LIT |=> accum == $past(accum ^ lit) &&
      status[STAT_C] == $past(status[STAT_C]) && status[STAT_DC] == $past(status[STAT_DC]))
    else $error("literal xor wrong or carry touched");
  AST_DIR_B: assert property (
    exec_go && op == OP_LOAD_DIR && lit == DIR_SEL_B |=>
      port_b_direction_o == $past(accum) && $stable(status) && $stable(port_a_direction_o))
    else $error("direction load to port b wrong");
  AST_XOR_FILE: assert property (
    exec_go && op == OP_XOR_FILE && !dest_file |=> accum == $past(accum ^ file_sel))
    else $error("file xor into accumulator wrong");
  AST_ZERO: assert property (
    exec_go && (op == OP_XOR_LIT || (op == OP_XOR_FILE && !dest_file)) |=>
      status[STAT_Z] == (accum == 8'h00))
    else $error("zero flag does not match result");
  AST_PREADY: assert property (
    psel_i && !penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("apb ready not a single access cycle");

  COV_SUB: cover property (exec_go && op == OP_SUB_BORROW && !status[STAT_C]);
  COV_SWAP_FILE: cover property (exec_go && op == OP_NIBBLE_SWAP && dest_file);
  COV_DIR_C: cover property (exec_go && op == OP_LOAD_DIR && lit == DIR_SEL_C);
  COV_BAD_ADDR: cover property (access && pslverr_o);

endmodule

// file: hw/ssx_pkg.sv
// shared constants and types for the subtract/swap/xor/direction datapath
package ssx_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the apb bus
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_ACCUM = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_EXEC = 12'h008;
  localparam logic [11:0] ADDR_DIR_A = 12'h00C;
  localparam logic [11:0] ADDR_DIR_B = 12'h010;
  localparam logic [11:0] ADDR_DIR_C = 12'h014;
  // file registers sit at 0x200 + 4 * index
  localparam logic [2:0] FILE_REGION = 3'h1;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int STAT_C = 0;
  localparam int STAT_DC = 1;
  localparam int STAT_Z = 2;
  localparam int EXEC_DEST_BIT = 3;
  localparam int EXEC_OPND_LSB = 4;
  localparam int FILE_DEPTH = 128;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ACCUM_RST = 8'h00;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [11:0] EXEC_RST = 12'h000;

  // ----------------------------------------------------------------
  // direction-load operand codes
  // ----------------------------------------------------------------
  localparam logic [7:0] DIR_SEL_A = 8'h05;
  localparam logic [7:0] DIR_SEL_B = 8'h06;
  localparam logic [7:0] DIR_SEL_C = 8'h07;

  // instruction codes written to the exec register
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SUB_BORROW = 3'h1,
    OP_NIBBLE_SWAP = 3'h2,
    OP_XOR_LIT = 3'h3,
    OP_LOAD_DIR = 3'h4,
    OP_XOR_FILE = 3'h5
  } ssx_op_t;

endpackage

// file: hw/ssx_alu.sv
// combinational arithmetic unit: result and flags for one instruction
module ssx_alu
  import ssx_pkg::*;
(
  input  wire ssx_op_t    op_i,       // decoded instruction
  input  wire logic [7:0] accum_i,    // accumulator value
  input  wire logic [7:0] file_i,     // addressed file register value
  input  wire logic [7:0] lit_i,      // 8-bit literal
  input  wire logic       carry_i,    // current carry (inverted borrow)
  output logic      [7:0] result_o,   // instruction result
  output logic            carry_o,    // new carry
  output logic            dcarry_o,   // new digit carry
  output logic            zero_o,     // new zero flag
  output logic            upd_cdc_o,  // carry and digit carry change
  output logic            upd_z_o,    // zero flag changes
  output logic            has_res_o   // result goes to a destination
);

  logic [8:0] sum9;
  logic [4:0] sum5;

  // ----------------------------------------------------------------
  // subtract as f + ~w + c, so carry out is the inverted borrow
  // ----------------------------------------------------------------
  assign sum9 = {1'b0, file_i} + {1'b0, ~accum_i} + {8'h00, carry_i};
  assign sum5 = {1'b0, file_i[3:0]} + {1'b0, ~accum_i[3:0]} + {4'h0, carry_i};

  // result and flag selection per instruction
  always_comb begin
    result_o = 8'h00;
    upd_cdc_o = 1'b0;
    upd_z_o = 1'b0;
    has_res_o = 1'b0;
    case (op_i)
      OP_SUB_BORROW: begin
        result_o = sum9[7:0];
        upd_cdc_o = 1'b1;
        upd_z_o = 1'b1;
        has_res_o = 1'b1;
      end
      OP_NIBBLE_SWAP: begin
        result_o = {file_i[3:0], file_i[7:4]};  // flags untouched
        has_res_o = 1'b1;
      end
      OP_XOR_LIT: begin
        result_o = accum_i ^ lit_i;
        upd_z_o = 1'b1;
        has_res_o = 1'b1;
      end
      OP_XOR_FILE: begin
        result_o = accum_i ^ file_i;
        upd_z_o = 1'b1;
        has_res_o = 1'b1;
      end
      default: begin
        result_o = 8'h00;
      end
    endcase
  end

  // carry clears when w plus borrow exceeds f, same test on the low nibble
  assign carry_o = sum9[8];
  assign dcarry_o = sum5[4];
  assign zero_o = (result_o == 8'h00);

endmodule

// file: test/ssx_testbench.sv
// self-checking bench for the subtract/swap/xor/direction datapath
module testbench
  import ssx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [7:0] dir_a;
  logic [7:0] dir_b;
  logic [7:0] dir_c;
  int err_total = 0;
  int compares = 0;
  logic [31:0] rd;
  logic err;

  // 100 ns period
  always #50 clk_i = ~clk_i;

  ssx_datapath dut_u (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .port_a_direction_o(dir_a),
    .port_b_direction_o(dir_b),
    .port_c_direction_o(dir_c)
  );

  // ----------------------------------------------------------------
  // reporting and bus tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; the request is held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) begin
      n++;
      if (n > 16) begin
        err_total++;
        $display("ERROR t=%0t no ready, addr %h waited %h", $time, a, n);
        finish_test();
      end
      @(posedge clk_i);
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0000_0000);
  endtask

  function automatic logic [11:0] fa(input logic [6:0] n);
    return 12'h200 + {3'h0, n, 2'b00};
  endfunction

  task automatic exec(input ssx_op_t op, input logic d, input logic [7:0] opnd);
    apb(1'b1, ADDR_EXEC, {20'h0, opnd, d, op});
  endtask

  task automatic setup(input logic [6:0] n, input logic [7:0] f, input logic [7:0] w,
                       input logic [2:0] st);
    apb(1'b1, fa(n), {24'h0, f});
    apb(1'b1, ADDR_ACCUM, {24'h0, w});
    apb(1'b1, ADDR_STATUS, {29'h0, st});
  endtask

  // destination routing: the untouched side must keep its old value
  task automatic res_chk(input logic [6:0] n, input logic d, input logic [7:0] f,
                         input logic [7:0] w, input logic [7:0] r, input logic [2:0] st);
    rdchk(ADDR_ACCUM, {24'h0, d ? w : r});
    rdchk(fa(n), {24'h0, d ? r : f});
    rdchk(ADDR_STATUS, {29'h0, st});
  endtask

  // reference: {zero, digit carry, carry, result}; f - w - borrow, carry set
  // unless w plus borrow exceeds f, kept apart from the adder form of the unit
  function automatic logic [10:0] sub_ref(input logic [7:0] f, input logic [7:0] w,
                                          input logic c);
    logic [7:0] d;
    logic [8:0] sub;
    logic [4:0] lo;
    d = f - w - {7'h00, ~c};
    sub = {1'b0, w} + {8'h00, ~c};
    lo = {1'b0, w[3:0]} + {4'h0, ~c};
    return {d == 8'h00, {1'b0, f[3:0]} >= lo, {1'b0, f} >= sub, d};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    logic [10:0] e;
    logic [7:0] w;
    logic [7:0] r;
    logic [7:0] sel;
    logic [2:0] st;
    logic [6:0] n;
    logic [7:0] tf[5];
    logic [7:0] tw[5];
    logic tc[5];
    logic [7:0] tk[3];
    tf = '{8'h20, 8'h11, 8'h0F, 8'h10, 8'h80};
    tw = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h01};
    tc = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    tk = '{8'h5A, 8'hFF, 8'h00};
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    chk({8'h00, dir_a, dir_b, dir_c}, 32'h00FF_FFFF);
    rdchk(ADDR_ACCUM, 32'h0000_0000);
    rdchk(ADDR_STATUS, 32'h0000_0000);
    rdchk(fa(7'd127), 32'h0000_0000);
    $display("test reset done");
    // boundary addresses 127 and 3, borrow in and out, zero result
    for (i = 0; i < 5; i++) begin
      n = 7'(127 - i * 31);
      e = sub_ref(tf[i], tw[i], tc[i]);
      setup(n, tf[i], tw[i], {2'b11, tc[i]});
      exec(OP_SUB_BORROW, i[0], {1'b0, n});
      res_chk(n, i[0], tf[i], tw[i], e[7:0], e[10:8]);
    end
    $display("test subtract done");
    // swap keeps flags; file xor moves only the zero flag, both ways
    for (i = 0; i < 4; i++) begin
      w = i[0] ? 8'h3C : 8'hA5;
      st = i[0] ? 3'h7 : 3'h0;
      n = 7'(40 + i);
      setup(n, 8'hA5, w, st);
      exec(i[1] ? OP_XOR_FILE : OP_NIBBLE_SWAP, i[0], {1'b0, n});
      r = i[1] ? (8'hA5 ^ w) : 8'h5A;
      st = i[1] ? {r == 8'h00, st[1:0]} : st;
      res_chk(n, i[0], 8'hA5, w, r, st);
    end
    $display("test swap and file xor done");
    // destination bit set on purpose: the literal form always lands in the accumulator
    for (i = 0; i < 3; i++) begin
      setup(7'd0, 8'h00, 8'h5A, 3'h3);
      exec(OP_XOR_LIT, 1'b1, tk[i]);
      r = 8'h5A ^ tk[i];
      res_chk(7'd0, 1'b0, 8'h00, 8'h5A, r, {r == 8'h00, 2'b11});
    end
    $display("test literal xor done");
    // selects 5, 6, 7 then an out-of-range 4 that must load nothing
    for (i = 0; i < 4; i++) begin
      sel = (i < 3) ? 8'(5 + i) : 8'h04;
      setup(7'd1, 8'h00, 8'(8'h11 * (i + 1)), 3'h5);
      exec(OP_LOAD_DIR, 1'b0, sel);
      rdchk(ADDR_STATUS, 32'h0000_0005);
    end
    // a direction write is ignored without error; look one edge later, once it would land
    apb(1'b1, ADDR_DIR_A, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0000);
    @(posedge clk_i);
    chk({8'h00, dir_a, dir_b, dir_c}, 32'h0011_2233);
    rdchk(ADDR_DIR_A, 32'h0000_0011);
    rdchk(ADDR_DIR_B, 32'h0000_0022);
    rdchk(ADDR_DIR_C, 32'h0000_0033);
    rdchk(ADDR_EXEC, 32'h0000_0044);
    $display("test direction load done");
    // unmapped and unaligned places answer with an error and zero data
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b0, 12'h002, 32'h0000_0000);
    chk({err, rd[30:0]}, 32'h8000_0000);
    $display("test refused access done");
    finish_test();
  end
endmodule
